// *** design/usr_regs.svh ***
// Register addresses, bit positions and masks of the status block.
`ifndef USR_REGS_SVH
`define USR_REGS_SVH
`define USR_A_RXHOLD  3'h0
`define USR_A_INTEN   3'h1
`define USR_A_FIFOCTL 3'h2
`define USR_A_MODCTL  3'h4
`define USR_A_LINEST  3'h5
`define USR_A_MODST   3'h6
`define USR_A_SPARE   3'h7
`define USR_LS_DR     0
`define USR_LS_OVR    1
`define USR_LS_PAR    2
`define USR_LS_FRM    3
`define USR_LS_BRK    4
`define USR_LS_TXE    5
`define USR_LS_TEMT   6
`define USR_LS_FERR   7
`define USR_MC_DTR    0
`define USR_MC_RTS    1
`define USR_MC_RDY    2
`define USR_MC_IRQE   3
`define USR_MC_LOOP   4
`define USR_MC_XANY   5
`define USR_MC_TLEN   6
`define USR_MC_DIV4   7
`define USR_EF_ENH    4
`define USR_FC_RXCLR  1
`define USR_IE_SLEEP  4
`define USR_IE_SRC    8'hef
`define USR_LOW_MASK  8'h0f
`define USR_HIGH_MASK 8'hf0
`define USR_MC_GATE   8'he0
`define USR_ZERO8     8'h00
`define USR_BRK_CHAR  8'h00
`endif

// *** design/usr_pkg.sv ***
// Types shared by the status register block.
package usr_pkg;
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic cd;
  } usr_modem_t;
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } usr_err_t;
  typedef struct packed {
    logic [7:0] data;
    usr_err_t   err;
  } usr_char_t;
  typedef enum logic [1:0] {
    USR_RX_IDLE,
    USR_RX_BREAK
  } usr_rx_state_t;
endpackage

// *** design/usr_rx_fifo.sv ***
// Receive character store with per-entry error flags.
`timescale 1ns/1ps
module usr_rx_fifo #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             push,
  input  wire usr_pkg::usr_char_t wdata,
  input  wire logic             pop,
  output usr_pkg::usr_char_t    head,
  output logic                  not_empty,
  output logic                  full,
  output logic                  any_err
);
  typedef struct packed {
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [AW:0]   cnt;
    logic [DEPTH-1:0] errv;
  } usr_fifo_state_t;
  usr_fifo_state_t s_q, s_d;
  usr_pkg::usr_char_t mem_q [DEPTH];
  logic do_push;
  logic do_pop;
  assign full      = (s_q.cnt == (AW+1)'(DEPTH));
  assign not_empty = (s_q.cnt != '0);
  assign do_push   = push && !full;
  assign do_pop    = pop && not_empty;
  assign head      = mem_q[s_q.rp];
  assign any_err   = |s_q.errv;
  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.wp = s_q.wp + 1'b1;
      s_d.errv[s_q.wp] = |wdata.err;
    end
    if (do_pop) begin
      s_d.rp = s_q.rp + 1'b1;
      s_d.errv[s_q.rp] = 1'b0;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (clr) begin
      s_d = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[s_q.wp] <= wdata;
    end
  end
endmodule // usr_rx_fifo

// *** design/usr_status_regs.sv ***
// Line status, modem control, modem status and interrupt enable registers.
`timescale 1ns/1ps
`include "usr_regs.svh"
module usr_status_regs #(
  parameter int FIFO_DEPTH = 64,
  parameter int FIFO_AW    = 6
) (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic       RD,
  input  wire logic       WR,
  input  wire logic [7:0] DIN,
  output logic      [7:0] DOUT,
  input  wire logic       CLOCK_SELECT_PIN,
  input  wire logic       RX_PUSH,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_PARITY_FLAG,
  input  wire logic       RX_STOP_OK,
  input  wire logic       RX_LINE,
  input  wire logic       CHAR_TIME_TICK,
  input  wire logic       TX_LINE,
  input  wire logic       TX_HOLD_EMPTY,
  input  wire logic       TX_SHIFT_EMPTY,
  input  wire logic       AUTO_RTS_EN,
  input  wire logic       AUTO_RTS_LEVEL,
  input  wire logic       XOFF_PEND,
  input  wire logic       RTS_PEND,
  input  wire logic       CTS_PEND,
  input  wire logic       CTS_N,
  input  wire logic       DSR_N,
  input  wire logic       RI_N,
  input  wire logic       CD_N,
  output logic            DTR_N,
  output logic            RTS_N,
  output logic            RX_LINE_INT,
  output logic            IRQ_O,
  output logic            IRQ_OE,
  output logic            FIFO_READY_EN,
  output logic            XON_ANY_EN,
  output logic            CTRL_TRIG_ACCESS,
  output logic            CLK_DIV4,
  output logic            SLEEP_EN,
  output logic            RX_OVERRUN_DROP
);
  typedef struct packed {
    logic [7:0]          mctl;
    logic [7:0]          ien;
    logic [7:0]          efeat;
    logic                overrun;
    logic                fifo_err;
    logic [3:0]          delta;
    usr_pkg::usr_modem_t modem_prev;
    logic                tx_armed;
    logic                strap_done;
    usr_pkg::usr_rx_state_t rx_st;
    logic [7:0]          dout;
  } usr_state_t;
  usr_state_t s_q, s_d;

  usr_pkg::usr_char_t  head;
  usr_pkg::usr_char_t  wchar;
  usr_pkg::usr_modem_t modem_now;
  logic       rx_nonempty;
  logic       rx_full;
  logic       rx_any_err;
  logic       rx_pop;
  logic       rx_clr;
  logic       push;
  logic       rx_in;
  logic       enh_sel;
  logic       int_pend;
  logic [7:0] int_src;
  logic [3:0] modem_chg;
  logic [7:0] rd_mux;
  logic [7:0] ls_val;
  logic [7:0] ms_val;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] keep);
    merge = (old_v & keep) | (new_v & ~keep);
  endfunction

  assign rx_in = s_q.mctl[`USR_MC_LOOP] ? TX_LINE : RX_LINE;
  assign RX_LINE_INT = rx_in;
  // Register page selection beyond this block is fixed at the plain page.
  assign enh_sel = 1'b0;

  assign rx_pop = RD && hit(ADDR, `USR_A_RXHOLD);
  assign rx_clr = WR && hit(ADDR, `USR_A_FIFOCTL) && !enh_sel
                  && DIN[`USR_FC_RXCLR];

  always_comb begin
    wchar.data    = RX_DATA;
    wchar.err.par = RX_PARITY_FLAG;
    wchar.err.frm = !RX_STOP_OK;
    wchar.err.brk = 1'b0;
    push          = RX_PUSH;
    if (s_q.rx_st == usr_pkg::USR_RX_IDLE && !rx_in && CHAR_TIME_TICK) begin
      wchar.data    = `USR_BRK_CHAR;
      wchar.err.brk = 1'b1;
      wchar.err.frm = 1'b1;
      wchar.err.par = 1'b0;
      push          = 1'b1;
    end
  end
  assign RX_OVERRUN_DROP = push && rx_full;

  usr_rx_fifo #(
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk       (MCLK),
    .rst       (RST),
    .clr       (rx_clr),
    .push      (push),
    .wdata     (wchar),
    .pop       (rx_pop),
    .head      (head),
    .not_empty (rx_nonempty),
    .full      (rx_full),
    .any_err   (rx_any_err)
  );

  always_comb begin
    if (s_q.mctl[`USR_MC_LOOP]) begin
      modem_now.cts = s_q.mctl[`USR_MC_RTS];
      modem_now.dsr = s_q.mctl[`USR_MC_DTR];
      modem_now.ri  = s_q.mctl[`USR_MC_RDY];
      modem_now.cd  = s_q.mctl[`USR_MC_IRQE];
    end else begin
      modem_now.cts = !CTS_N;
      modem_now.dsr = !DSR_N;
      modem_now.ri  = !RI_N;
      modem_now.cd  = !CD_N;
    end
  end

  always_comb begin
    ls_val = `USR_ZERO8;
    ls_val[`USR_LS_DR]   = rx_nonempty;
    ls_val[`USR_LS_OVR]  = s_q.overrun;
    ls_val[`USR_LS_PAR]  = head.err.par;
    ls_val[`USR_LS_FRM]  = head.err.frm;
    ls_val[`USR_LS_BRK]  = head.err.brk;
    ls_val[`USR_LS_TXE]  = TX_HOLD_EMPTY;
    ls_val[`USR_LS_TEMT] = TX_HOLD_EMPTY && TX_SHIFT_EMPTY;
    ls_val[`USR_LS_FERR] = rx_any_err || s_q.fifo_err;
  end
  assign ms_val = {modem_now.cd, modem_now.ri, modem_now.dsr, modem_now.cts,
                   s_q.delta[3], s_q.delta[2], s_q.delta[1], s_q.delta[0]};

  always_comb begin
    modem_chg[0] = modem_now.cts != s_q.modem_prev.cts;
    modem_chg[1] = modem_now.dsr != s_q.modem_prev.dsr;
    modem_chg[2] = modem_now.ri && !s_q.modem_prev.ri;
    modem_chg[3] = modem_now.cd != s_q.modem_prev.cd;
  end

  always_comb begin
    int_src = `USR_ZERO8;
    int_src[0] = rx_nonempty;
    int_src[1] = TX_HOLD_EMPTY && s_q.tx_armed;
    int_src[2] = s_q.overrun || rx_any_err;
    int_src[3] = |s_q.delta;
    int_src[5] = XOFF_PEND;
    int_src[6] = RTS_PEND;
    int_src[7] = CTS_PEND;
  end
  // Enable bit 4 is the sleep select, not a source, so it is masked out.
  assign int_pend = |(int_src & s_q.ien & `USR_IE_SRC);

  // Idle read data is zero, so the bus can be shared by a wired OR.
  always_comb begin
    rd_mux = `USR_ZERO8;
    case (ADDR)
      `USR_A_RXHOLD: rd_mux = head.data;
      `USR_A_INTEN:  rd_mux = s_q.ien;
      `USR_A_MODCTL: rd_mux = s_q.mctl;
      `USR_A_LINEST: rd_mux = ls_val;
      `USR_A_MODST:  rd_mux = ms_val;
      `USR_A_SPARE:  rd_mux = s_q.efeat;
      default:       rd_mux = `USR_ZERO8;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.modem_prev = modem_now;
    s_d.strap_done = 1'b1;
    // The strap is taken once, on the first edge after release; a control
    // write in that same cycle would lose bit 7, so hosts wait one edge.
    // Strap after release.
    if (!s_q.strap_done) begin
      s_d.mctl[`USR_MC_DIV4] = !CLOCK_SELECT_PIN;
    end
    // Break is reported once per low period; the state waits for the line
    // to return high before it can report again.
    case (s_q.rx_st)
      usr_pkg::USR_RX_IDLE: begin
        if (!rx_in && CHAR_TIME_TICK) begin
          s_d.rx_st = usr_pkg::USR_RX_BREAK;
        end
      end
      usr_pkg::USR_RX_BREAK: begin
        if (rx_in) begin
          s_d.rx_st = usr_pkg::USR_RX_IDLE;
        end
      end
      default: s_d.rx_st = usr_pkg::USR_RX_IDLE;
    endcase
    // Reads clear sticky bits before new events so a same-cycle event wins.
    if (RD && hit(ADDR, `USR_A_LINEST)) begin
      s_d.overrun = 1'b0;
    end
    if (RD && hit(ADDR, `USR_A_MODST)) begin
      s_d.delta = 4'h0;
    end
    if (push && rx_full) begin
      s_d.overrun = 1'b1;
    end
    s_d.delta = s_d.delta | modem_chg;
    // The error summary holds until a clear, so a stray empty read is never
    // lost; an empty read in the clearing cycle still wins.
    if (rx_clr) begin
      s_d.fifo_err = 1'b0;
    end
    if (rx_pop && !rx_nonempty) begin
      s_d.fifo_err = 1'b1;
    end
    if (WR && hit(ADDR, `USR_A_RXHOLD)) begin
      s_d.tx_armed = 1'b1;
    end
    if (WR && hit(ADDR, `USR_A_INTEN)) begin
      if (s_q.efeat[`USR_EF_ENH]) begin
        s_d.ien = DIN;
      end else begin
        s_d.ien = merge(s_q.ien, DIN, `USR_HIGH_MASK);
      end
      if (DIN[1] && !s_q.ien[1]) begin
        s_d.tx_armed = 1'b0;
      end
    end
    if (WR && hit(ADDR, `USR_A_MODCTL)) begin
      if (s_q.efeat[`USR_EF_ENH]) begin
        s_d.mctl = DIN;
      end else begin
        s_d.mctl = merge(s_q.mctl, DIN, `USR_MC_GATE);
      end
    end
    if (WR && hit(ADDR, `USR_A_SPARE)) begin
      s_d.efeat = DIN;
    end
    // Read data is registered, so it appears after the edge that samples the strobe and stays stable for one cycle.
    s_d.dout = RD ? rd_mux : `USR_ZERO8;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      // Transmit interrupt starts armed, as an empty holding register after
      // reset is a genuine event.
      s_q <= '0;
      s_q.tx_armed <= 1'b1;
      s_q.modem_prev <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign DOUT = s_q.dout;
  // Active-low modem outputs.
  // Loopback parks the modem outputs inactive so the far side sees no pulse.
  assign DTR_N = s_q.mctl[`USR_MC_LOOP] ? 1'b1 : !s_q.mctl[`USR_MC_DTR];
  assign RTS_N = s_q.mctl[`USR_MC_LOOP] ? 1'b1 :
                 AUTO_RTS_EN ? AUTO_RTS_LEVEL : !s_q.mctl[`USR_MC_RTS];
  assign FIFO_READY_EN = s_q.mctl[`USR_MC_RDY] && !s_q.mctl[`USR_MC_LOOP];
  assign IRQ_OE = s_q.mctl[`USR_MC_IRQE];
  assign IRQ_O  = int_pend;
  assign XON_ANY_EN       = s_q.mctl[`USR_MC_XANY];
  assign CTRL_TRIG_ACCESS = s_q.mctl[`USR_MC_TLEN];
  assign CLK_DIV4 = s_q.mctl[`USR_MC_DIV4];
  assign SLEEP_EN = s_q.ien[`USR_IE_SLEEP];
endmodule // usr_status_regs

// *** testbench/usr_status_props.sv ***
// Port-level checker of the status register block.
`timescale 1ns/1ps
module usr_status_props (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [2:0] ADDR,
  input wire logic       WR,
  input wire logic [7:0] DIN,
  input wire logic       CLOCK_SELECT_PIN,
  input wire logic       TX_LINE,
  input wire logic       RX_LINE,
  input wire logic       XOFF_PEND,
  input wire logic       DTR_N,
  input wire logic       RX_LINE_INT,
  input wire logic       IRQ_O,
  input wire logic       IRQ_OE,
  input wire logic       XON_ANY_EN,
  input wire logic       CTRL_TRIG_ACCESS,
  input wire logic       CLK_DIV4,
  input wire logic       SLEEP_EN
);
  logic enh_q;
  logic xie_q;
  wire  mw = WR && ADDR == 3'h4;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Shadows of the enhanced-feature enable and of interrupt enable bit 5, so gated writes can be judged.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      enh_q <= 1'b0;
      xie_q <= 1'b0;
    end else begin
      if (WR && ADDR == 3'h7) enh_q <= DIN[4];
      if (WR && ADDR == 3'h1 && enh_q) xie_q <= DIN[5];
    end
  end
  property p_gate_hold;
    mw && !enh_q |=> $stable({XON_ANY_EN, CTRL_TRIG_ACCESS, CLK_DIV4});
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gated control bits moved");
  property p_gate_set;
    mw && enh_q |=> {CLK_DIV4, CTRL_TRIG_ACCESS, XON_ANY_EN} == $past(DIN[7:5]);
  endproperty
  a_gate_set: assert property (p_gate_set)
    else $error("gated control bits not written");
  property p_div_load;
    $fell(RST) |=> CLK_DIV4 == !$past(CLOCK_SELECT_PIN);
  endproperty
  a_div_load: assert property (p_div_load)
    else $error("prescale not loaded from pin");
  property p_irq_oe;
    mw |=> IRQ_OE == $past(DIN[3]);
  endproperty
  a_irq_oe: assert property (p_irq_oe)
    else $error("interrupt enable pin wrong");
  property p_dtr;
    mw && !DIN[4] |=> DTR_N == !$past(DIN[0]);
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("dtr level wrong");
  property p_loop;
    mw && DIN[4] |=> RX_LINE_INT == TX_LINE;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback line wrong");
  property p_noloop;
    mw && !DIN[4] |=> RX_LINE_INT == RX_LINE;
  endproperty
  a_noloop: assert property (p_noloop)
    else $error("receive line wrong");
  property p_sleep;
    WR && ADDR == 3'h1 && enh_q |=> SLEEP_EN == $past(DIN[4]);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep enable wrong");
  property p_irq;
    xie_q && XOFF_PEND && IRQ_OE |-> ##[0:1] IRQ_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled source gave no interrupt");
  c_loop: cover property (mw && DIN[4]);
  c_irq: cover property (xie_q && XOFF_PEND);
  c_enh: cover property (mw && enh_q);
endmodule // usr_status_props
bind usr_status_regs usr_status_props u_usr_status_props (.MCLK, .RST,
  .ADDR, .WR, .DIN, .CLOCK_SELECT_PIN, .TX_LINE, .RX_LINE, .XOFF_PEND,
  .DTR_N, .RX_LINE_INT, .IRQ_O, .IRQ_OE, .XON_ANY_EN, .CTRL_TRIG_ACCESS,
  .CLK_DIV4, .SLEEP_EN);

// *** testbench/usr_host.sv ***
// Host processor model on the byte-wide register bus.
`timescale 1ns/1ps
module usr_host (
  input wire logic MCLK,
  output logic [2:0] ADDR,
  output logic       RD,
  output logic       WR,
  output logic [7:0] DIN
);
  initial begin
    {RD, WR, ADDR, DIN} = 13'h0000;
  end
  // Released address and data lines show inverted values so stale data is never trusted.
  task automatic access(input logic w, input logic [2:0] a,
                        input logic [7:0] d);
    @(negedge MCLK);
    {RD, WR, ADDR, DIN} = {!w, w, a, d};
    @(negedge MCLK);
    {RD, WR, ADDR, DIN} = {2'b00, ~a, ~d};
  endtask
endmodule // usr_host

// *** testbench/tb_top.sv ***
// Self-checking bench for the status register block.
`timescale 1ns/1ps
module tb_top;
  logic MCLK = 1'b0, RST = 1'b1;
  logic [2:0] ADDR;
  logic RD, WR, RX_PUSH, RX_PARITY_FLAG, RX_STOP_OK, RX_LINE, TX_LINE;
  logic [7:0] DIN, DOUT, RX_DATA;
  logic CLOCK_SELECT_PIN, CHAR_TIME_TICK, TX_HOLD_EMPTY, TX_SHIFT_EMPTY;
  logic AUTO_RTS_EN, AUTO_RTS_LEVEL, XOFF_PEND, RTS_PEND, CTS_PEND;
  logic CTS_N, DSR_N, RI_N, CD_N, DTR_N, RTS_N, RX_LINE_INT, IRQ_O, IRQ_OE;
  logic FIFO_READY_EN, XON_ANY_EN, CTRL_TRIG_ACCESS, CLK_DIV4, SLEEP_EN;
  logic RX_OVERRUN_DROP, rd_d = 1'b0;
  logic [15:0] q[$], n;
  logic [7:0] d[3], ex[3] = '{8'he5, 8'he9, 8'h61};
  int n_errors = 0, check_count = 0, seed = 32'ha3b2;
  wire [7:0] pins = {DTR_N, RTS_N, IRQ_OE, FIFO_READY_EN, XON_ANY_EN,
                     CTRL_TRIG_ACCESS, CLK_DIV4, SLEEP_EN};
  usr_status_regs u_usr_status_regs (.MCLK, .RST, .ADDR, .RD, .WR, .DIN,
    .DOUT, .CLOCK_SELECT_PIN, .RX_PUSH, .RX_DATA, .RX_PARITY_FLAG,
    .RX_STOP_OK, .RX_LINE, .CHAR_TIME_TICK, .TX_LINE, .TX_HOLD_EMPTY,
    .TX_SHIFT_EMPTY, .AUTO_RTS_EN, .AUTO_RTS_LEVEL, .XOFF_PEND, .RTS_PEND,
    .CTS_PEND, .CTS_N, .DSR_N, .RI_N, .CD_N, .DTR_N, .RTS_N, .RX_LINE_INT,
    .IRQ_O, .IRQ_OE, .FIFO_READY_EN, .XON_ANY_EN, .CTRL_TRIG_ACCESS,
    .CLK_DIV4, .SLEEP_EN, .RX_OVERRUN_DROP);
  usr_host u_usr_host (.MCLK, .ADDR, .RD, .WR, .DIN);
  always #50 MCLK = ~MCLK;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    q.push_back({m, e});
    u_usr_host.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    u_usr_host.access(1'b1, a, v);
  endtask
  task automatic push(input logic [7:0] v, input logic p, input logic s);
    @(negedge MCLK);
    {RX_DATA, RX_PARITY_FLAG, RX_STOP_OK, RX_PUSH} = {v, p, s, 1'b1};
    @(negedge MCLK);
    RX_PUSH = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read data is due one cycle after the strobe and stands one cycle.
  always @(posedge MCLK) rd_d <= RD;
  always @(negedge MCLK) begin
    if (rd_d && q.size() > 0) begin
      n = q.pop_front();
      chk("read data", n[7:0] & n[15:8], DOUT & n[15:8]);
    end
  end
  initial begin
    {RX_PUSH, RX_PARITY_FLAG, CHAR_TIME_TICK, AUTO_RTS_EN, XOFF_PEND} = 5'h00;
    {RTS_PEND, CTS_PEND, CLOCK_SELECT_PIN, TX_LINE, RX_DATA} = 12'h000;
    {RX_STOP_OK, RX_LINE, TX_HOLD_EMPTY, TX_SHIFT_EMPTY} = 4'hf;
    {AUTO_RTS_LEVEL, CTS_N, DSR_N, RI_N, CD_N} = 5'h1f;
    repeat (8) @(negedge MCLK);
    RST = 1'b0;
    rd(3'h4, 8'h80);
    rd(3'h1, 8'h00);
    rd(3'h5, 8'h60, 8'he3);
    rd(3'h6, 8'h00);
    rd(3'h3, 8'h00);
    $display("reset values done");
    wr(3'h4, 8'h6f);
    rd(3'h4, 8'h8f);
    chk("pins", 8'h32, pins);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h0f);
    wr(3'h7, 8'h10);
    wr(3'h4, 8'h6f);
    rd(3'h4, 8'h6f);
    wr(3'h1, 8'h30);
    rd(3'h1, 8'h30);
    chk("pins", 8'h3d, pins);
    XOFF_PEND = 1'b1;
    repeat (2) @(negedge MCLK);
    chk("irq", 8'h01, {7'h00, IRQ_O});
    XOFF_PEND = 1'b0;
    wr(3'h1, 8'h10);
    XOFF_PEND = 1'b1;
    repeat (2) @(negedge MCLK);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    {XOFF_PEND, AUTO_RTS_EN} = 2'b01;
    @(negedge MCLK);
    chk("rts_n", 8'h01, {7'h00, RTS_N});
    wr(3'h1, 8'h12);
    chk("irq", 8'h00, {7'h00, IRQ_O});
    wr(3'h0, 8'h55);
    chk("irq", 8'h01, {7'h00, IRQ_O});
    wr(3'h1, 8'h10);
    {AUTO_RTS_EN, TX_SHIFT_EMPTY} = 2'b00;
    rd(3'h5, 8'h20, 8'he3);
    TX_SHIFT_EMPTY = 1'b1;
    $display("control and enable done");
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      push(d[i], i == 0, i != 1);
    end
    for (int i = 0; i < 3; i++) begin
      rd(3'h5, ex[i]);
      rd(3'h5, ex[i]);
      rd(3'h0, d[i]);
    end
    {RX_LINE, CHAR_TIME_TICK} = 2'b01;
    @(negedge MCLK);
    {RX_LINE, CHAR_TIME_TICK} = 2'b10;
    rd(3'h5, 8'hf9);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h60, 8'he3);
    rd(3'h0, 8'h00, 8'h00);
    rd(3'h5, 8'he0, 8'he3);
    wr(3'h2, 8'h02);
    rd(3'h5, 8'h60, 8'he3);
    for (int i = 0; i < 65; i++) begin
      push(8'($random(seed)), 1'b0, 1'b1);
    end
    rd(3'h5, 8'h03, 8'h03);
    rd(3'h5, 8'h01, 8'h03);
    wr(3'h2, 8'h02);
    $display("receive status done");
    {CTS_N, CD_N} = 2'b00;
    rd(3'h6, 8'h99);
    rd(3'h6, 8'h90);
    {CTS_N, CD_N} = 2'b11;
    rd(3'h6, 8'h09);
    wr(3'h4, 8'h1b);
    @(negedge MCLK);
    chk("rx_line_int", 8'h00, {7'h00, RX_LINE_INT});
    rd(3'h6, 8'hb0, 8'hf0);
    wr(3'h4, 8'h00);
    repeat (3) @(negedge MCLK);
    $display("modem status done");
    end_sim();
  end
  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // tb_top
